// ===== power_down_pkg.sv
// Constants shared by the power-down mode controller.
// Contract
// - Decode bits 15:10; zero none, others reserved
// - Code 001001: light sleep, enabled interrupt wakes
// - Code 010001: light sleep, any interrupt wakes
// - Light sleep gates CPU clocks, interrupts watched
// - DMA keeps running during light sleep
// - Code 011010: PLL output stops, reset wakes
// - Middle and deep sleep preserve register contents
// - Middle and deep sleep freeze functional outputs
// - Code 011100: PLL input stops, reset wakes
// - After reset wait for PLL lock
// - Async peripherals unspecified in middle, deep sleep
// - Light sleep effective eight cycles after write
// - Wake resumes; service only with all enables
// - Mode and wake taken from control field
package power_down_pkg;
	// Register map, byte addresses
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] IRQ_EN_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	// Control/status fields
	localparam int SLEEP_FIELD_LSB = 10;
	localparam int SLEEP_FIELD_MSB = 15;
	localparam int GLOBAL_EN_BIT = 0;
	localparam int NMI_EN_BIT = 1;
	localparam int IRQ_EN_WIDTH = 16;
	// Sleep-select codes
	localparam logic [5:0] CODE_NONE = 6'h00;
	localparam logic [5:0] CODE_LIGHT_ENABLED = 6'h09;
	localparam logic [5:0] CODE_LIGHT_ANY = 6'h11;
	localparam logic [5:0] CODE_MIDDLE = 6'h1A;
	localparam logic [5:0] CODE_DEEP = 6'h1C;
	// Reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
	// Cycles from the field write to light sleep taking effect
	localparam int LIGHT_DELAY_CYCLES = 8;
	// Status register bit positions
	localparam int ST_LOCK_WAIT_BIT = 0;
	localparam int ST_ARMED_BIT = 1;
	localparam int ST_LIGHT_BIT = 2;
	localparam int ST_MIDDLE_BIT = 3;
	localparam int ST_DEEP_BIT = 4;
	typedef enum logic [2:0] {
		ST_LOCK_WAIT,
		ST_RUN,
		ST_ARM,
		ST_LIGHT,
		ST_MIDDLE,
		ST_DEEP
	} pd_state_t;
endpackage

// ===== power_down_mode_control.sv
// Power-down mode controller: sleep-level sequencing, clock gating and wake.
`timescale 1ns/1ps
`default_nettype none
module power_down_mode_control #(
	parameter int IRQ_WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [31:0] rdata_o,
	// Wake sources and PLL status, asynchronous pins
	input wire logic [IRQ_WIDTH-1:0] irq_i,
	input wire logic pll_locked_i,
	// Clock and I/O controls
	output logic cpu_clock_enable_o,
	output logic dma_enable_o,
	output logic pll_output_enable_o,
	output logic pll_input_enable_o,
	output logic io_freeze_o,
	output logic periph_unspecified_o,
	// CPU resume handshake
	output logic resume_o,
	output logic isr_request_o
);
	initial begin
		if (IRQ_WIDTH < 2 || IRQ_WIDTH > power_down_pkg::IRQ_EN_WIDTH) begin
			$error("IRQ_WIDTH must be 2 to 16");
		end
	end

	// Two less: the write edge and the edge that leaves ST_ARM at count zero each add a cycle
	localparam logic [3:0] ARM_LOAD = 4'(power_down_pkg::LIGHT_DELAY_CYCLES - 2);

	// Synchronisers
	logic [IRQ_WIDTH-1:0] irq_meta_reg;
	logic [IRQ_WIDTH-1:0] irq_sync_reg;
	logic lock_meta_reg;
	logic lock_sync_reg;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_meta_reg <= '0;
			irq_sync_reg <= '0;
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			irq_meta_reg <= irq_i;
			irq_sync_reg <= irq_meta_reg;
			lock_meta_reg <= pll_locked_i;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// Registers
	power_down_pkg::pd_state_t state_reg, state_next;
	logic [5:0] sleep_select_field_reg;
	logic [5:0] sleep_select_field_next;
	logic global_interrupt_enable_reg;
	logic global_interrupt_enable_next;
	logic [power_down_pkg::IRQ_EN_WIDTH-1:0] interrupt_enable_reg;
	logic [power_down_pkg::IRQ_EN_WIDTH-1:0] interrupt_enable_next;
	logic [3:0] arm_count_reg;
	logic [3:0] arm_count_next;
	logic [31:0] rdata_next;

	// Decode
	wire ctrl_hit = addr_i == power_down_pkg::CTRL_OFFSET;
	wire irq_en_hit = addr_i == power_down_pkg::IRQ_EN_OFFSET;
	wire status_hit = addr_i == power_down_pkg::STATUS_OFFSET;
	// Writes only while the CPU runs; sleeping levels keep contents
	wire cpu_awake = state_reg == power_down_pkg::ST_RUN || state_reg == power_down_pkg::ST_ARM;
	wire ctrl_write = write_i && ctrl_hit && cpu_awake;
	wire irq_en_write = write_i && irq_en_hit && cpu_awake;
	wire [5:0] wr_field = wdata_i[power_down_pkg::SLEEP_FIELD_MSB:power_down_pkg::SLEEP_FIELD_LSB];
	// Reserved codes fall through to no power-down
	wire is_light_code = wr_field == power_down_pkg::CODE_LIGHT_ENABLED
		|| wr_field == power_down_pkg::CODE_LIGHT_ANY;
	wire is_middle_code = wr_field == power_down_pkg::CODE_MIDDLE;
	wire is_deep_code = wr_field == power_down_pkg::CODE_DEEP;
	wire nmi_enable = interrupt_enable_reg[power_down_pkg::NMI_EN_BIT];
	wire [IRQ_WIDTH-1:0] irq_en_slice = interrupt_enable_reg[IRQ_WIDTH-1:0];
	wire any_irq = |irq_sync_reg;
	wire enabled_irq = |(irq_sync_reg & irq_en_slice);
	wire wake_any = sleep_select_field_reg == power_down_pkg::CODE_LIGHT_ANY && any_irq;
	wire wake_enabled = sleep_select_field_reg == power_down_pkg::CODE_LIGHT_ENABLED
		&& enabled_irq;
	wire light_wake = state_reg == power_down_pkg::ST_LIGHT && (wake_any || wake_enabled);
	wire run_isr = enabled_irq && global_interrupt_enable_reg && nmi_enable;

	wire [31:0] ctrl_view = {16'h0000, sleep_select_field_reg, 9'h000,
		global_interrupt_enable_reg};
	wire [31:0] irq_en_view = {16'h0000, interrupt_enable_reg};
	wire [31:0] status_view = {27'h000_0000,
		state_reg == power_down_pkg::ST_DEEP,
		state_reg == power_down_pkg::ST_MIDDLE,
		state_reg == power_down_pkg::ST_LIGHT,
		state_reg == power_down_pkg::ST_ARM,
		state_reg == power_down_pkg::ST_LOCK_WAIT};
	// Unmapped reads return zero
	assign rdata_next = !read_i ? 32'h0000_0000 :
		ctrl_hit ? ctrl_view :
		irq_en_hit ? irq_en_view :
		status_hit ? status_view : 32'h0000_0000;

	always_comb begin
		state_next = state_reg;
		sleep_select_field_next = sleep_select_field_reg;
		global_interrupt_enable_next = global_interrupt_enable_reg;
		interrupt_enable_next = interrupt_enable_reg;
		arm_count_next = arm_count_reg;
		if (ctrl_write) begin
			sleep_select_field_next = wr_field;
			global_interrupt_enable_next = wdata_i[power_down_pkg::GLOBAL_EN_BIT];
		end
		if (irq_en_write) begin
			interrupt_enable_next = wdata_i[power_down_pkg::IRQ_EN_WIDTH-1:0];
		end
		case (state_reg)
			power_down_pkg::ST_LOCK_WAIT: begin
				if (lock_sync_reg) begin
					state_next = power_down_pkg::ST_RUN;
				end
			end
			power_down_pkg::ST_RUN, power_down_pkg::ST_ARM: begin
				if (ctrl_write && is_middle_code) begin
					state_next = power_down_pkg::ST_MIDDLE;
				end else if (ctrl_write && is_deep_code) begin
					state_next = power_down_pkg::ST_DEEP;
				end else if (ctrl_write && is_light_code) begin
					state_next = power_down_pkg::ST_ARM;
					arm_count_next = ARM_LOAD;
				end else if (ctrl_write) begin
					state_next = power_down_pkg::ST_RUN;
				end else if (state_reg == power_down_pkg::ST_ARM) begin
					if (arm_count_reg == 4'h0) begin
						state_next = power_down_pkg::ST_LIGHT;
					end else begin
						arm_count_next = arm_count_reg - 4'h1;
					end
				end
			end
			power_down_pkg::ST_LIGHT: begin
				if (light_wake) begin
					state_next = power_down_pkg::ST_RUN;
					sleep_select_field_next = power_down_pkg::CODE_NONE;
				end
			end
			// Left only through reset
			power_down_pkg::ST_MIDDLE: state_next = power_down_pkg::ST_MIDDLE;
			power_down_pkg::ST_DEEP: state_next = power_down_pkg::ST_DEEP;
			default: state_next = power_down_pkg::ST_LOCK_WAIT;
		endcase
	end

	// Output next values
	wire cpu_clock_enable_next = state_next == power_down_pkg::ST_RUN
		|| state_next == power_down_pkg::ST_ARM;
	// DMA runs in light sleep, not in the clock-stopped levels
	wire dma_enable_next = cpu_clock_enable_next
		|| state_next == power_down_pkg::ST_LIGHT;
	wire clocks_stopped_next = state_next == power_down_pkg::ST_MIDDLE
		|| state_next == power_down_pkg::ST_DEEP;
	wire pll_output_enable_next = !clocks_stopped_next;
	wire pll_input_enable_next = state_next != power_down_pkg::ST_DEEP;
	wire resume_next = light_wake;
	wire isr_request_next = light_wake && run_isr;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= power_down_pkg::ST_LOCK_WAIT;
			sleep_select_field_reg <= power_down_pkg::CTRL_RESET[power_down_pkg::SLEEP_FIELD_MSB:
				power_down_pkg::SLEEP_FIELD_LSB];
			global_interrupt_enable_reg <= power_down_pkg::CTRL_RESET[power_down_pkg::GLOBAL_EN_BIT];
			interrupt_enable_reg <= power_down_pkg::IRQ_EN_RESET;
			arm_count_reg <= 4'h0;
			rdata_o <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			sleep_select_field_reg <= sleep_select_field_next;
			global_interrupt_enable_reg <= global_interrupt_enable_next;
			interrupt_enable_reg <= interrupt_enable_next;
			arm_count_reg <= arm_count_next;
			rdata_o <= rdata_next;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_clock_enable_o <= 1'b0;
			dma_enable_o <= 1'b0;
			pll_output_enable_o <= 1'b1;
			pll_input_enable_o <= 1'b1;
			io_freeze_o <= 1'b0;
			periph_unspecified_o <= 1'b0;
			resume_o <= 1'b0;
			isr_request_o <= 1'b0;
		end else begin
			cpu_clock_enable_o <= cpu_clock_enable_next;
			dma_enable_o <= dma_enable_next;
			pll_output_enable_o <= pll_output_enable_next;
			pll_input_enable_o <= pll_input_enable_next;
			io_freeze_o <= clocks_stopped_next;
			// Async or externally clocked peripherals may still toggle
			periph_unspecified_o <= clocks_stopped_next;
			resume_o <= resume_next;
			isr_request_o <= isr_request_next;
		end
	end

	// Checks
	sequence light_write_s;
		ctrl_write && is_light_code;
	endsequence
	sequence quiet_bus_s;
		!write_i [*7];
	endsequence

	chk_light_delay: assert property (@(posedge clk_i) disable iff (reset_i)
		light_write_s ##1 quiet_bus_s |-> ##1 !cpu_clock_enable_o && $past(cpu_clock_enable_o))
		else $error("light sleep not effective eight cycles after write");

	chk_light_gates_cpu: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == power_down_pkg::ST_LIGHT |-> !cpu_clock_enable_o && dma_enable_o
			&& pll_output_enable_o)
		else $error("light sleep clock controls wrong");

	chk_dma_light: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(state_reg == power_down_pkg::ST_LIGHT) |-> dma_enable_o)
		else $error("dma stalled in light sleep");

	chk_enabled_wake: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == power_down_pkg::ST_LIGHT
			&& sleep_select_field_reg == power_down_pkg::CODE_LIGHT_ENABLED && !enabled_irq
			|=> state_reg == power_down_pkg::ST_LIGHT)
		else $error("light sleep left without enabled interrupt");

	chk_any_wake: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == power_down_pkg::ST_LIGHT
			&& sleep_select_field_reg == power_down_pkg::CODE_LIGHT_ANY && any_irq
			|=> cpu_clock_enable_o && resume_o)
		else $error("light sleep not left on interrupt");

	chk_middle_stuck: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == power_down_pkg::ST_MIDDLE |=> state_reg == power_down_pkg::ST_MIDDLE
			&& !pll_output_enable_o && pll_input_enable_o)
		else $error("middle sleep left without reset");

	chk_deep_stuck: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == power_down_pkg::ST_DEEP |=> state_reg == power_down_pkg::ST_DEEP
			&& !pll_input_enable_o)
		else $error("deep sleep left without reset");

	chk_hold_contents: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_reg == power_down_pkg::ST_MIDDLE || state_reg == power_down_pkg::ST_DEEP)
			|=> $stable(interrupt_enable_reg) && $stable(sleep_select_field_reg))
		else $error("register contents changed in stopped sleep");

	chk_freeze_io: assert property (@(posedge clk_i) disable iff (reset_i)
		io_freeze_o |-> !pll_output_enable_o && periph_unspecified_o)
		else $error("outputs not frozen with clocks stopped");

	chk_lock_wait: assert property (@(posedge clk_i) disable iff (reset_i)
		!lock_sync_reg && state_reg == power_down_pkg::ST_LOCK_WAIT |=> !cpu_clock_enable_o)
		else $error("cpu clocked before pll lock");

	chk_isr_gate: assert property (@(posedge clk_i) disable iff (reset_i)
		isr_request_o |-> resume_o && $past(global_interrupt_enable_reg) && $past(nmi_enable))
		else $error("service request without enables");

	chk_reserved_code: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_write && !is_light_code && !is_middle_code && !is_deep_code
			|=> state_reg == power_down_pkg::ST_RUN)
		else $error("reserved code caused power-down");

	chk_resume_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		resume_o |=> !resume_o && !isr_request_o && cpu_clock_enable_o)
		else $error("resume pulse longer than one cycle");

	chk_field_write: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_write |=> sleep_select_field_reg == $past(wr_field))
		else $error("sleep field not taken from write");

	chk_middle_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_write && is_middle_code |=> io_freeze_o && !pll_output_enable_o && !dma_enable_o)
		else $error("middle sleep not entered in one cycle");

	chk_lock_release: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == power_down_pkg::ST_LOCK_WAIT && lock_sync_reg |=> cpu_clock_enable_o)
		else $error("cpu not clocked after pll lock");
endmodule
`default_nettype wire

// ===== tb_power_down_mode_control.sv
// Self-checking testbench for the power-down mode controller.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_power_down_mode_control;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic write_i = 1'b0;
	logic read_i = 1'b0;
	logic [31:0] rdata_o;
	logic [15:0] irq_i = 16'h0000;
	logic pll_locked_i = 1'b0;
	logic cpu_clock_enable_o, dma_enable_o, pll_output_enable_o, pll_input_enable_o;
	logic io_freeze_o, periph_unspecified_o, resume_o, isr_request_o;
	int err_count = 0;
	int n_compared = 0;
	logic [31:0] rd;
	int n;
	logic [5:0] wake_code [4];
	int wake_bit [4];
	logic [15:0] wake_en [4];
	logic wake_isr [4];
	logic [5:0] hold_code [2];

	power_down_mode_control #(.IRQ_WIDTH(16)) DUT (
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .irq_i(irq_i),
		.pll_locked_i(pll_locked_i), .cpu_clock_enable_o(cpu_clock_enable_o),
		.dma_enable_o(dma_enable_o), .pll_output_enable_o(pll_output_enable_o),
		.pll_input_enable_o(pll_input_enable_o), .io_freeze_o(io_freeze_o),
		.periph_unspecified_o(periph_unspecified_o), .resume_o(resume_o),
		.isr_request_o(isr_request_o)
	);

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	function automatic logic [31:0] ctrl_word(input logic [5:0] code, input logic g);
		return (32'(code) << power_down_pkg::SLEEP_FIELD_LSB) | 32'(g);
	endfunction

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		write_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		write_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		read_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		read_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	// Counts edges until the chosen output reaches val; a spent bound ends the run
	task automatic wait_out(input int which, input logic val, input int bound, output int cnt);
		logic s;
		cnt = 0;
		do begin
			@(posedge clk_i);
			#1;
			cnt++;
			s = (which == 0) ? cpu_clock_enable_o : (which == 1) ? resume_o : pll_output_enable_o;
		end while (s !== val && cnt < bound);
		if (s !== val) begin
			err_count++;
			$display("ERROR t=%0t wait expired got=%h exp=%h", $time, s, val);
			conclude();
		end
	endtask

	// Reset with the PLL unlocked, then let it lock
	task automatic boot();
		reset_i <= 1'b1;
		pll_locked_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		`CHECK({cpu_clock_enable_o, pll_output_enable_o, pll_input_enable_o}, 3'b011)
		reset_i <= 1'b0;
		reg_read(power_down_pkg::CTRL_OFFSET, rd);
		`CHECK(rd, power_down_pkg::CTRL_RESET)
		reg_write(power_down_pkg::IRQ_EN_OFFSET, 32'h0000_0006);
		repeat (6) @(posedge clk_i);
		reg_read(power_down_pkg::STATUS_OFFSET, rd);
		`CHECK(rd[power_down_pkg::ST_LOCK_WAIT_BIT], 1'b1)
		`CHECK(cpu_clock_enable_o, 1'b0)
		pll_locked_i <= 1'b1;
		wait_out(0, 1'b1, 10, n);
		reg_read(power_down_pkg::IRQ_EN_OFFSET, rd);
		`CHECK(rd, 32'(power_down_pkg::IRQ_EN_RESET))
	endtask

	initial begin
		wake_code = '{power_down_pkg::CODE_LIGHT_ENABLED, power_down_pkg::CODE_LIGHT_ENABLED,
			power_down_pkg::CODE_LIGHT_ANY, power_down_pkg::CODE_LIGHT_ANY};
		wake_bit = '{2, 2, 5, 2};
		wake_en = '{16'h0004, 16'h0006, 16'h0006, 16'h0006};
		wake_isr = '{1'b0, 1'b1, 1'b0, 1'b1};
		hold_code = '{power_down_pkg::CODE_MIDDLE, power_down_pkg::CODE_DEEP};
		boot();
		// Reserved code is kept but does not sleep
		reg_write(power_down_pkg::CTRL_OFFSET, ctrl_word(6'h01, 1'b1));
		repeat (12) @(posedge clk_i);
		`CHECK(cpu_clock_enable_o, 1'b1)
		reg_read(power_down_pkg::CTRL_OFFSET, rd);
		`CHECK(rd, ctrl_word(6'h01, 1'b1))
		reg_read(8'h3C, rd);
		`CHECK(rd, 32'h0000_0000)
		for (int i = 0; i < 4; i++) begin
			reg_write(power_down_pkg::IRQ_EN_OFFSET, 32'(wake_en[i]));
			reg_write(power_down_pkg::CTRL_OFFSET, ctrl_word(wake_code[i], 1'b1));
			wait_out(0, 1'b0, 12, n);
			// Count starts one edge after the write edge
			`CHECK(n + 1, power_down_pkg::LIGHT_DELAY_CYCLES)
			`CHECK(dma_enable_o, 1'b1)
			`CHECK(pll_output_enable_o, 1'b1)
			reg_read(power_down_pkg::STATUS_OFFSET, rd);
			`CHECK(rd[power_down_pkg::ST_LIGHT_BIT], 1'b1)
			if (wake_code[i] == power_down_pkg::CODE_LIGHT_ENABLED) begin
				irq_i <= 16'h0008;
				repeat (8) @(posedge clk_i);
				`CHECK({cpu_clock_enable_o, resume_o}, 2'b00)
				irq_i <= 16'h0000;
				repeat (3) @(posedge clk_i);
			end
			irq_i <= 16'(1) << wake_bit[i];
			wait_out(1, 1'b1, 8, n);
			`CHECK(isr_request_o, wake_isr[i])
			`CHECK(cpu_clock_enable_o, 1'b1)
			irq_i <= 16'h0000;
			repeat (4) @(posedge clk_i);
			reg_read(power_down_pkg::CTRL_OFFSET, rd);
			`CHECK(rd[15:10], power_down_pkg::CODE_NONE)
		end
		for (int i = 0; i < 2; i++) begin
			reg_write(power_down_pkg::IRQ_EN_OFFSET, 32'h0000_0024);
			reg_write(power_down_pkg::CTRL_OFFSET, ctrl_word(hold_code[i], 1'b1));
			wait_out(2, 1'b0, 3, n);
			`CHECK(pll_input_enable_o, i == 0)
			`CHECK({cpu_clock_enable_o, dma_enable_o}, 2'b00)
			`CHECK({io_freeze_o, periph_unspecified_o}, 2'b11)
			if (i == 1) begin
				pll_locked_i <= 1'b0;
			end
			irq_i <= 16'h0024;
			reg_write(power_down_pkg::IRQ_EN_OFFSET, 32'h0000_0000);
			repeat (8) @(posedge clk_i);
			`CHECK({cpu_clock_enable_o, pll_output_enable_o, io_freeze_o}, 3'b001)
			reg_read(power_down_pkg::IRQ_EN_OFFSET, rd);
			`CHECK(rd, 32'h0000_0024)
			reg_read(power_down_pkg::CTRL_OFFSET, rd);
			`CHECK(rd, ctrl_word(hold_code[i], 1'b1))
			irq_i <= 16'h0000;
			boot();
			`CHECK({io_freeze_o, pll_output_enable_o, pll_input_enable_o}, 3'b011)
		end
		conclude();
	end

	initial begin
		#200000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
